// *** rtl/tsc_top.sv ***
// Conversion control for a 12-bit touch screen converter
// Operation
// [RULE_01] Host writes primary control last, after every other setting.
// [RULE_02] Host goes idle, changes settings, then rewrites primary control.
// [RULE_03] Both control registers reset to zero, so the block starts idle.
// [RULE_04] Primary control: diff flag 11, channel 10:7, read address, mode 1:0.
// [RULE_05] Mode 00 idle, 01 single, 10 slave sequence, 11 master sequence.
// [RULE_06] Single mode converts the channel named in the primary control.
// [RULE_07] Single or slave run with timer 00 clears mode back to idle.
// [RULE_08] A nonzero timer code repeats the run at its interval.
// [RULE_09] Mode 10 converts every channel enabled in the slave sequencer.
// [RULE_10] Mode 11 waits for touch, then converts master sequencer channels.
// [RULE_11] After a master run wait for fresh touch or timer with touch held.
// [RULE_12] Diff flag clear is single-ended, set is ratiometric, in every mode.
// [RULE_13] Channel codes 0 to 10 are valid, 11 to 15 invalid.
// [RULE_14] Timer 00 once, 01 every 1024, 10 every 2048, 11 every 16384 clocks.
// [RULE_15] In slave mode the timer starts as soon as a run completes.
// [RULE_16] Master timer runs only while touched; release stops it.
// [RULE_17] Reference select set makes the pin an input, internal ref off.
// [RULE_18] Secondary control: mean, window, policy, startup, sense, ref, timer.
// [RULE_19] Sequencer bit 11 enables channel 0 down to bit 1 for channel 10.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tsc_top #(
	parameter int TMR_LONG_CYC = tsc_pkg::TMR_LONG_CYC
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [3:0]  avs_byteenable_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Converter core
	output logic             conv_start_out,
	output logic [3:0]       conv_chan_out,
	output logic             conv_diff_out,
	input  wire logic        conv_done_in,
	// Touch detect and reference
	input  wire logic        touch_in,
	output logic             ref_pin_input_out,
	output logic             int_ref_off_out
);
	logic [11:0] ctrl_pri_q;
	logic [11:0] ctrl_pri_d;
	logic [11:0] ctrl_sec_q;
	logic [11:0] seq_slv_q;
	logic [11:0] seq_mst_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        done_s;
	logic        done_prev_q;
	logic        touch_s;
	tsc_pkg::tsc_state_t state_q;
	tsc_pkg::tsc_state_t state_d;
	logic [3:0]  chan_q;
	logic [3:0]  chan_d;
	logic        start_d;
	logic        diff_q;
	logic        clr_mode;
	logic        tmr_go;
	logic        tmr_halt;
	tsc_tmr_if tmr_bus ();

	tsc_sync u_done_sync (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (conv_done_in),
		.q_out   (done_s)
	);

	tsc_sync u_touch_sync (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    (touch_in),
		.q_out   (touch_s)
	);

	tsc_timer #(
		.LONG_CYC (TMR_LONG_CYC)
	) u_timer (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.tmr     (tmr_bus)
	);

	// Byte-lane merge of a 12-bit register
	function automatic logic [11:0] merge(input logic [11:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge = old;
		if (be[0])
			merge[7:0] = wd[7:0];
		if (be[1])
			merge[11:8] = wd[11:8];
	endfunction

	// Sequencer bit 11 is channel 0, bit 1 is channel 10
	function automatic logic [10:0] chan_mask(input logic [11:0] seq);
		for (int i = 0; i <= 10; i++) begin
			chan_mask[i] = seq[11 - i];
		end
	endfunction

	// Lowest enabled channel at or above a start point
	function automatic logic [3:0] next_chan(input logic [10:0] m,
		input logic [4:0] from);
		next_chan = tsc_pkg::CHAN_NONE;
		for (int i = 10; i >= 0; i--) begin
			if (m[i] && 5'(i) >= from) begin
				next_chan = 4'(i);
			end
		end
	endfunction

	// Field decoding
	wire tsc_pkg::tsc_mode_t mode =
		tsc_pkg::tsc_mode_t'(ctrl_pri_q[tsc_pkg::MODE_LSB +: 2]);
	wire [3:0]  chan_code = ctrl_pri_q[tsc_pkg::CHAN_LSB +: 4];
	wire        diff_flag = ctrl_pri_q[tsc_pkg::DIFF_POS];
	wire [1:0]  interval  = ctrl_sec_q[tsc_pkg::TMR_LSB +: 2];
	wire        ref_sel   = ctrl_sec_q[tsc_pkg::REFSEL_POS];
	wire        master    = mode == tsc_pkg::MODE_SEQ_MS;
	wire        single    = mode == tsc_pkg::MODE_SINGLE;
	wire [10:0] mask      = chan_mask(master ? seq_mst_q : seq_slv_q);
	wire [3:0]  first_seq = next_chan(mask, 5'h00);
	wire [3:0]  later_seq = next_chan(mask, {1'b0, chan_q} + 5'h01);
	wire [3:0]  first_ch  = single
		? (chan_code <= tsc_pkg::CHAN_LAST ? chan_code
		: tsc_pkg::CHAN_NONE) : first_seq;
	wire        done_evt  = done_s && !done_prev_q;

	// Bus decode
	wire req      = avs_read_in || avs_write_in;
	wire wr_take  = avs_write_in && ack_q;
	wire hit_pri  = avs_address_in == tsc_pkg::OFF_CTRL_PRI;
	wire hit_sec  = avs_address_in == tsc_pkg::OFF_CTRL_SEC;
	wire hit_sslv = avs_address_in == tsc_pkg::OFF_SEQ_SLV;
	wire hit_smst = avs_address_in == tsc_pkg::OFF_SEQ_MST;
	wire hit_stat = avs_address_in == tsc_pkg::OFF_STATUS;
	wire wr_pri   = wr_take && hit_pri;
	wire [31:0] status = {21'h000000, tmr_bus.expired, touch_s, chan_q,
		state_q, mode};
	wire [31:0] rd_mux =
		hit_pri  ? {20'h00000, ctrl_pri_q} :
		hit_sec  ? {20'h00000, ctrl_sec_q} :
		hit_sslv ? {20'h00000, seq_slv_q} :
		hit_smst ? {20'h00000, seq_mst_q} :
		hit_stat ? status : 32'h00000000;

	// One wait cycle per access; unmapped reads give zero
	assign avs_waitrequest_out = req && !ack_q;
	assign avs_readdata_out    = rdata_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= req && !ack_q;
			rdata_q <= rd_mux;
		end
	end

	// A host write beats the hardware clearing the mode
	always_comb begin
		ctrl_pri_d = ctrl_pri_q;
		if (wr_pri) begin
			ctrl_pri_d = merge(ctrl_pri_q, avs_writedata_in,
				avs_byteenable_in);
		end else if (clr_mode) begin
			ctrl_pri_d[tsc_pkg::MODE_LSB +: 2] = tsc_pkg::MODE_IDLE; // RULE_07
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_pri_q <= tsc_pkg::CTRL_PRI_RST; // RULE_03
			ctrl_sec_q <= tsc_pkg::CTRL_SEC_RST; // RULE_03
			seq_slv_q  <= tsc_pkg::SEQ_RST;
			seq_mst_q  <= tsc_pkg::SEQ_RST;
		end else begin
			ctrl_pri_q <= ctrl_pri_d; // RULE_04
			if (wr_take && hit_sec) begin
				ctrl_sec_q <= merge(ctrl_sec_q, avs_writedata_in,
					avs_byteenable_in); // RULE_18
			end
			if (wr_take && hit_sslv) begin
				seq_slv_q <= merge(seq_slv_q, avs_writedata_in,
					avs_byteenable_in);
			end
			if (wr_take && hit_smst) begin
				seq_mst_q <= merge(seq_mst_q, avs_writedata_in,
					avs_byteenable_in);
			end
		end
	end

	// Sequencer; a primary write always restarts from its new mode
	always_comb begin
		state_d  = state_q;
		chan_d   = chan_q;
		start_d  = 1'b0;
		clr_mode = 1'b0;
		tmr_go   = 1'b0;
		tmr_halt = 1'b0;
		if (wr_pri) begin
			tmr_halt = 1'b1;
			case (tsc_pkg::tsc_mode_t'(ctrl_pri_d[tsc_pkg::MODE_LSB +: 2]))
				tsc_pkg::MODE_IDLE:   state_d = tsc_pkg::ST_IDLE; // RULE_05
				tsc_pkg::MODE_SEQ_MS: state_d = tsc_pkg::ST_ARM; // RULE_10
				default:              state_d = tsc_pkg::ST_LAUNCH;
			endcase
		end else begin
			case (state_q)
				tsc_pkg::ST_LAUNCH: begin
					// Invalid codes or an empty list end the run at once
					if (first_ch != tsc_pkg::CHAN_NONE) begin // RULE_13
						chan_d  = first_ch; // RULE_06 RULE_09
						start_d = 1'b1;
						state_d = tsc_pkg::ST_WAIT;
					end else begin
						state_d = tsc_pkg::ST_DONE;
					end
				end
				tsc_pkg::ST_WAIT: begin
					if (done_evt) begin
						if (!single && later_seq != tsc_pkg::CHAN_NONE) begin
							chan_d  = later_seq; // RULE_09 RULE_19
							start_d = 1'b1;
						end else begin
							state_d = tsc_pkg::ST_DONE;
						end
					end
				end
				tsc_pkg::ST_DONE: begin
					if (master) begin
						if (!touch_s) begin
							state_d = tsc_pkg::ST_ARM; // RULE_11
						end else if (interval != tsc_pkg::TMR_ONCE) begin
							tmr_go  = 1'b1; // RULE_16
							state_d = tsc_pkg::ST_REPEAT;
						end else begin
							state_d = tsc_pkg::ST_RELEASE; // RULE_11
						end
					end else if (interval == tsc_pkg::TMR_ONCE) begin
						clr_mode = 1'b1; // RULE_07
						state_d  = tsc_pkg::ST_IDLE;
					end else begin
						tmr_go  = 1'b1; // RULE_08 RULE_15
						state_d = tsc_pkg::ST_REPEAT;
					end
				end
				tsc_pkg::ST_REPEAT: begin
					if (master && !touch_s) begin
						tmr_halt = 1'b1; // RULE_16
						state_d  = tsc_pkg::ST_ARM;
					end else if (tmr_bus.expired) begin
						state_d = tsc_pkg::ST_LAUNCH; // RULE_08
					end
				end
				tsc_pkg::ST_ARM: begin
					if (touch_s) begin
						state_d = tsc_pkg::ST_LAUNCH; // RULE_10 RULE_16
					end
				end
				tsc_pkg::ST_RELEASE: begin
					if (!touch_s) begin
						state_d = tsc_pkg::ST_ARM; // RULE_11
					end
				end
				default: begin
					state_d = tsc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign tmr_bus.start = tmr_go;
	assign tmr_bus.stop  = tmr_halt;
	assign tmr_bus.code  = interval; // RULE_14

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q     <= tsc_pkg::ST_IDLE;
			chan_q      <= 4'h0;
			diff_q      <= 1'b0;
			done_prev_q <= 1'b0;
			conv_start_out <= 1'b0;
		end else begin
			state_q     <= state_d;
			chan_q      <= chan_d;
			diff_q      <= start_d ? diff_flag : diff_q; // RULE_12
			done_prev_q <= done_s;
			conv_start_out <= start_d;
		end
	end

	assign conv_chan_out = chan_q;
	assign conv_diff_out = diff_q;

	// Reference select overrides any power policy for the reference
	assign ref_pin_input_out = ref_sel; // RULE_17
	assign int_ref_off_out   = ref_sel; // RULE_17

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	property p_reset_zero;
		!$past(nrst_in) |-> ctrl_pri_q == 12'h000 && ctrl_sec_q == 12'h000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) // RULE_03
		else $error("control registers not zero after reset");
	property p_mode_clear;
		state_q == tsc_pkg::ST_DONE && !master && !wr_pri
			&& interval == tsc_pkg::TMR_ONCE
			|=> mode == tsc_pkg::MODE_IDLE && state_q == tsc_pkg::ST_IDLE;
	endproperty
	a_mode_clear: assert property (p_mode_clear) // RULE_07
		else $error("mode not cleared after a one-shot run");
	property p_repeat;
		state_q == tsc_pkg::ST_DONE && !master && !wr_pri
			&& interval != tsc_pkg::TMR_ONCE
			|-> tmr_bus.start ##1 state_q == tsc_pkg::ST_REPEAT;
	endproperty
	a_repeat: assert property (p_repeat) // RULE_15
		else $error("slave timer not started at end of run");
	property p_single_chan;
		$rose(conv_start_out) && single && $stable(ctrl_pri_q)
			|-> conv_chan_out == chan_code;
	endproperty
	a_single_chan: assert property (p_single_chan) // RULE_06
		else $error("single conversion on wrong channel");
	property p_diff;
		conv_start_out |-> conv_diff_out == $past(diff_flag);
	endproperty
	a_diff: assert property (p_diff) // RULE_12
		else $error("conversion kind does not follow diff flag");
	property p_valid_chan;
		conv_start_out |-> conv_chan_out <= tsc_pkg::CHAN_LAST;
	endproperty
	a_valid_chan: assert property (p_valid_chan) // RULE_13
		else $error("conversion started on invalid channel");
	property p_seq_enabled;
		conv_start_out && !single && $stable(mask)
			|-> mask[conv_chan_out];
	endproperty
	a_seq_enabled: assert property (p_seq_enabled) // RULE_09
		else $error("sequence converted a disabled channel");
	property p_armed_waits;
		state_q == tsc_pkg::ST_ARM && !touch_s && !wr_pri
			|=> !conv_start_out [*2];
	endproperty
	a_armed_waits: assert property (p_armed_waits) // RULE_10
		else $error("master run began without touch");
	property p_release_stops;
		state_q == tsc_pkg::ST_REPEAT && master && !touch_s && !wr_pri
			|-> tmr_bus.stop ##1 state_q == tsc_pkg::ST_ARM;
	endproperty
	a_release_stops: assert property (p_release_stops) // RULE_16
		else $error("timer not stopped on touch release");
	property p_bus_answer;
		avs_read_in || avs_write_in |-> ##[0:1] !avs_waitrequest_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus request not answered in two cycles");
endmodule
`default_nettype wire

// *** rtl/tsc_pkg.sv ***
// Constants and types shared by the touch converter control block
package tsc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_PRI = 8'h00;
	localparam logic [7:0] OFF_CTRL_SEC = 8'h04;
	localparam logic [7:0] OFF_SEQ_SLV  = 8'h08;
	localparam logic [7:0] OFF_SEQ_MST  = 8'h0c;
	localparam logic [7:0] OFF_STATUS   = 8'h10;

	// Reset values
	localparam logic [11:0] CTRL_PRI_RST = 12'h000;
	localparam logic [11:0] CTRL_SEC_RST = 12'h000;
	localparam logic [11:0] SEQ_RST      = 12'h000;

	// Primary control fields
	localparam int DIFF_POS   = 11;
	localparam int CHAN_LSB   = 7;
	localparam int RDADDR_LSB = 3;
	localparam int MODE_LSB   = 0;

	// Secondary control fields
	localparam int MEAN_LSB    = 10;
	localparam int WINDOW_LSB  = 8;
	localparam int POLICY_LSB  = 6;
	localparam int STARTUP_LSB = 4;
	localparam int SENSE_POS   = 3;
	localparam int REFSEL_POS  = 2;
	localparam int TMR_LSB     = 0;

	// Channel codes
	localparam logic [3:0] CHAN_LAST = 4'ha;
	localparam logic [3:0] CHAN_NONE = 4'hf;

	// Repeat intervals in conversion clocks
	localparam int TMR_SHORT_CYC = 1024;
	localparam int TMR_MID_CYC   = 2048;
	localparam int TMR_LONG_CYC  = 16384;

	typedef enum logic [1:0] {
		MODE_IDLE   = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_SEQ_SL = 2'b10,
		MODE_SEQ_MS = 2'b11
	} tsc_mode_t;

	typedef enum logic [1:0] {
		TMR_ONCE  = 2'b00,
		TMR_SHORT = 2'b01,
		TMR_MID   = 2'b10,
		TMR_LONG  = 2'b11
	} tsc_tmr_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_LAUNCH  = 3'b001,
		ST_WAIT    = 3'b010,
		ST_DONE    = 3'b011,
		ST_REPEAT  = 3'b100,
		ST_ARM     = 3'b101,
		ST_RELEASE = 3'b110
	} tsc_state_t;
endpackage

// *** rtl/tsc_tmr_if.sv ***
// Handshake between the sequencer and the repeat timer
`timescale 1ns/10ps
`default_nettype none
interface tsc_tmr_if;
	logic       start;
	logic       stop;
	logic [1:0] code;
	logic       expired;
	modport owner (output start, output stop, output code, input expired);
	modport timer (input start, input stop, input code, output expired);
endinterface
`default_nettype wire

// *** rtl/tsc_sync.sv ***
// Two-flop synchroniser for one pin
`timescale 1ns/10ps
`default_nettype none
module tsc_sync (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Data
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** rtl/tsc_timer.sv ***
// Repeat interval timer counted in conversion clocks
`timescale 1ns/10ps
`default_nettype none
module tsc_timer #(
	parameter int LONG_CYC = tsc_pkg::TMR_LONG_CYC
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Sequencer side
	tsc_tmr_if.timer  tmr
);
	logic [14:0] cnt_q;
	logic        run_q;
	logic        exp_q;
	logic [14:0] load;

	function automatic logic [14:0] limit(input logic [1:0] code);
		case (code)
			tsc_pkg::TMR_SHORT: limit = 15'(tsc_pkg::TMR_SHORT_CYC - 1);
			tsc_pkg::TMR_MID:   limit = 15'(tsc_pkg::TMR_MID_CYC - 1);
			default:            limit = 15'(LONG_CYC - 1);
		endcase
	endfunction

	assign load        = limit(tmr.code);
	assign tmr.expired = exp_q;

	// Expiry shows one cycle more than the interval after the start pulse
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= 15'h0000;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else begin
			exp_q <= run_q && cnt_q == 15'h0000 && !tmr.stop && !tmr.start;
			if (tmr.stop) begin
				run_q <= 1'b0;
			end else if (tmr.start) begin
				run_q <= 1'b1;
				cnt_q <= load;
			end else if (run_q) begin
				if (cnt_q == 15'h0000) begin
					run_q <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 15'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/tsc_conv_model.sv ***
// Behavioural converter core that answers each start with a done level
`timescale 1ns/10ps
`default_nettype none
module tsc_conv_model (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Converter link
	input  wire logic start_in,
	input  wire logic slow_in,
	output logic      done_out
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	// Done is high for two cycles and always falls before the next start
	assign cnt_d = start_in ? (slow_in ? 6'h1e : 6'h04) :
		(cnt_q != 6'h00) ? cnt_q - 6'h01 : 6'h00;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= 6'h00;
			done_out <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_out <= (cnt_q == 6'h02) || (cnt_q == 6'h01);
		end
	end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the touch converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int LONG = 64;
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [3:0]  avs_byteenable_in = 4'hf;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        conv_start_out;
	logic [3:0]  conv_chan_out;
	logic        conv_diff_out;
	logic        conv_done_in;
	logic        touch_in = 1'b0;
	logic        slow = 1'b0;
	logic        ref_pin_input_out;
	logic        int_ref_off_out;
	logic [4:0]  conv_q[$];
	int          st_q[$];
	int          cyc = 0;
	int          n_fail = 0;
	int          check_count = 0;

	always #10 clk_in = ~clk_in;

	tsc_top #(.TMR_LONG_CYC(LONG)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.conv_start_out(conv_start_out), .conv_chan_out(conv_chan_out),
		.conv_diff_out(conv_diff_out), .conv_done_in(conv_done_in),
		.touch_in(touch_in), .ref_pin_input_out(ref_pin_input_out),
		.int_ref_off_out(int_ref_off_out));

	tsc_conv_model u_conv (.clk_in(clk_in), .nrst_in(nrst_in),
		.start_in(conv_start_out), .slow_in(slow), .done_out(conv_done_in));

	// Log every conversion start with its diff flag and channel
	always @(posedge clk_in) begin
		cyc++;
		if (conv_start_out === 1'b1) begin
			conv_q.push_back({conv_diff_out, conv_chan_out});
			st_q.push_back(cyc);
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One Avalon transfer: held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q,
		input logic [3:0] b = 4'hf);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_writedata_in <= d;
		avs_byteenable_in <= b;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		// One wait cycle, so ready shows at the second edge
		chk("wait cycles", 32'(n), 32'h2);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b = 4'hf);
		logic [31:0] q;
		xfer(1'b1, a, d, q, b);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(nm, q, e);
	endtask

	// Polls status until the mode field is back at idle
	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			xfer(1'b0, tsc_pkg::OFF_STATUS, 32'h0, q);
			n++;
		end while (q[1:0] !== 2'b00 && n < 400);
		chk("idle reached", 32'(n < 400), 32'h1);
	endtask

	task automatic t_reset();
		rd_chk(tsc_pkg::OFF_CTRL_PRI, 32'h0, "pri reset");
		rd_chk(tsc_pkg::OFF_CTRL_SEC, 32'h0, "sec reset");
		rd_chk(tsc_pkg::OFF_SEQ_SLV, 32'h0, "slv reset");
		rd_chk(tsc_pkg::OFF_SEQ_MST, 32'h0, "mst reset");
		chk("ref pin", 32'(ref_pin_input_out), 32'h0);
		wr(8'h14, 32'hffff_ffff);
		rd_chk(8'h14, 32'h0, "unmapped");
	endtask

	task automatic t_fields();
		wr(tsc_pkg::OFF_CTRL_SEC, 32'hffff_fffc);
		rd_chk(tsc_pkg::OFF_CTRL_SEC, 32'h0000_0ffc, "sec fields");
		chk("ref pin", 32'(ref_pin_input_out), 32'h1);
		chk("ref off", 32'(int_ref_off_out), 32'h1);
		wr(tsc_pkg::OFF_CTRL_SEC, 32'h0, 4'h1);
		rd_chk(tsc_pkg::OFF_CTRL_SEC, 32'h0000_0f00, "sec lane");
		chk("ref off", 32'(int_ref_off_out), 32'h0);
		wr(tsc_pkg::OFF_CTRL_SEC, 32'h0);
		wr(tsc_pkg::OFF_CTRL_PRI, 32'hffff_fffc);
		rd_chk(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0ffc, "pri fields");
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0);
	endtask

	task automatic t_single();
		logic [3:0] c;
		logic       d;
		for (int i = 0; i < 16; i++) begin
			c = i[3:0];
			d = c[0];
			slow <= c[1];
			conv_q.delete();
			wr(tsc_pkg::OFF_CTRL_PRI, {20'h0, d, c, 5'h00, 2'b01});
			wait_idle();
			chk("single count", conv_q.size(), (i <= 10) ? 1 : 0);
			if (conv_q.size() > 0)
				chk("single chan", conv_q[0], {d, c});
			rd_chk(tsc_pkg::OFF_CTRL_PRI, {20'h0, d, c, 7'h00}, "mode clr");
		end
	endtask

	task automatic t_slave();
		slow <= 1'b1;
		conv_q.delete();
		wr(tsc_pkg::OFF_SEQ_SLV, 32'h0000_0903);
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0802);
		wait_idle();
		chk("seq count", conv_q.size(), 3);
		chk("seq 0", conv_q[0], 5'h10);
		chk("seq 1", conv_q[1], 5'h13);
		chk("seq 2", conv_q[2], 5'h1a);
		slow <= 1'b0;
	endtask

	task automatic t_repeat();
		int n;
		int gap;
		for (int t = 1; t < 4; t++) begin
			n = (t == 1) ? 1024 : (t == 2) ? 2048 : LONG;
			conv_q.delete();
			st_q.delete();
			wr(tsc_pkg::OFF_CTRL_SEC, 32'(t));
			wr(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0281);
			for (int k = 0; k < n + 300 && st_q.size() < 2; k++)
				@(posedge clk_in);
			gap = (st_q.size() > 1) ? st_q[1] - st_q[0] : 0;
			chk("interval", 32'(gap >= n && gap <= n + 30), 32'h1);
			rd_chk(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0281, "mode kept");
			wr(tsc_pkg::OFF_CTRL_PRI, 32'h0);
			n = conv_q.size();
			repeat (LONG + 100) @(posedge clk_in);
			chk("stopped", conv_q.size(), n);
		end
		wr(tsc_pkg::OFF_CTRL_SEC, 32'h0);
	endtask

	task automatic t_master();
		int n;
		conv_q.delete();
		wr(tsc_pkg::OFF_SEQ_MST, 32'h0000_0400);
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0003);
		repeat (50) @(posedge clk_in);
		chk("no touch", conv_q.size(), 0);
		touch_in <= 1'b1;
		repeat (30) @(posedge clk_in);
		chk("touch run", conv_q.size(), 1);
		chk("touch chan", conv_q[0], 5'h01);
		repeat (200) @(posedge clk_in);
		chk("held once", conv_q.size(), 1);
		touch_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		touch_in <= 1'b1;
		repeat (30) @(posedge clk_in);
		chk("fresh touch", conv_q.size(), 2);
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0);
		wr(tsc_pkg::OFF_CTRL_SEC, 32'h3);
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0003);
		repeat (LONG * 2 + 60) @(posedge clk_in);
		chk("held repeat", 32'(conv_q.size() >= 4), 32'h1);
		touch_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		n = conv_q.size();
		repeat (LONG * 3) @(posedge clk_in);
		chk("timer stop", conv_q.size(), n);
		touch_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		chk("touch at once", conv_q.size(), n + 1);
		rd_chk(tsc_pkg::OFF_CTRL_PRI, 32'h0000_0003, "master mode");
		wr(tsc_pkg::OFF_CTRL_PRI, 32'h0);
		touch_in <= 1'b0;
	endtask

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (60000) @(posedge clk_in);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_fields();
		t_single();
		t_slave();
		t_repeat();
		t_master();
		wrap_up();
	end
endmodule
`default_nettype wire
